/* File: smc_map.svh */
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
`define SMC_CLK_NS 10
`define SMC_TICK_NS 1000000
`define SMC_DEB_TICKS 3'h4
`define SMC_MENU_HOLD_MS 13'h1388
`define SMC_DOT_HALF_MS 13'h01F4
`define SMC_ALT_MS 13'h0320
`define SMC_STORE_BLINK_MS 13'h07D0
`define SMC_CLR_HOLD_MS 13'h03E8
`define SMC_HOLD_SAT 13'h1FFF
`define SMC_CODE_MIN 6'h01
`define SMC_ADDR_DEF 6'h01
`define SMC_ADDR_MAX 6'h20
`define SMC_BAUD_DEF 6'h03
`define SMC_BAUD_MAX 6'h03
`define SMC_FMT_DEF 6'h01
`define SMC_FMT_MAX 6'h04
`define SMC_OFS_CTRL 12'h000
`define SMC_OFS_STATUS 12'h004
`define SMC_OFS_SETTINGS 12'h008
`define SMC_OFS_IRQ_STAT 12'h00C
`define SMC_OFS_IRQ_MASK 12'h010
`define SMC_IRQ_MENU 0
`define SMC_IRQ_STORED 1
`define SMC_IRQ_LOCK 2
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2
`endif

/* File: smc_menu.sv */
// Contract
// - Enter menu only after 5 s select hold while stopped, start off.
// - Centre dot blinks with 1 s period while in the menu.
// - Select press cycles pilot, address, baud, format, initialise.
// - Reset on pilot item shows dashes; start then runs, code blinking.
// - Pilot test on direct-ignition units drives only main valve 1.
// - Reset on address item shows stored address, default 1; select steps.
// - Reset stores value, item name blinks, then shows steadily.
// - Baud codes 1..3 for 4800/9600/19200, default 3, wrapping.
// - Format codes 1..4, default 1, even/odd parity, one/two stops.
// - Interrupted settings write locks out as E971, display alternating.
// - Clearing that lockout restores address 1, baud 3, format 1.
// - A 200 V unit on 100 V still accepts communication settings.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "smc_map.svh"
module smc_menu import smc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `SMC_TICK_NS / `SMC_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic display_select_button,
  input wire logic reset_button,
  input wire logic start_in,
  input wire logic seq_stopped,
  input wire logic nv_write_done,
  input wire logic commit_abort,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic menu_active,
  output logic dot_on,
  output smc_display_select_button_e display_select_button_kind,
  output smc_item_e display_select_button_item,
  output logic [5:0] display_select_button_value,
  output logic display_select_button_flash,
  output logic alt_sub,
  output logic pilot_run,
  output logic main_valve1_only,
  output logic nv_write_req,
  output logic comm_lockout,
  output logic [5:0] station_addr,
  output logic [1:0] baud_code,
  output logic [2:0] fmt_code,
  output logic irq
);
  logic [16:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  wire logic [1:0] btn_raw = {reset_button, display_select_button};
  wire logic [1:0] db;
  wire logic [1:0] press;
  wire logic [12:0] hold [2];
  smc_state_e state, next_state;
  smc_item_e item, next_item;
  logic [5:0] edit, next_edit;
  logic [12:0] tmr, next_tmr, bcnt, next_bcnt;
  logic done_seen, next_done_seen, direct_ign, next_direct_ign;
  logic [5:0] next_station_addr;
  logic [1:0] next_baud_code;
  logic [2:0] next_fmt_code;
  logic next_dot_on, next_alt_sub, next_display_select_button_flash;
  smc_display_select_button_e next_display_select_button_kind;
  logic [5:0] next_display_select_button_value;
  logic [2:0] ev, irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic display_select_button_hit, clr_hit;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // The millisecond tick paces debounce, hold timing and all blinking.
  always_comb begin
    next_tick = (tick_cnt == 17'(TICK_CYCLES - 1));
    next_tick_cnt = next_tick ? 17'h0 : tick_cnt + 17'h1;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 17'h0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_btn
    logic [2:0] cnt, next_cnt;
    logic db_q, next_db, press_q;
    logic [12:0] hold_q, next_hold;
    always_comb begin
      next_cnt = cnt;
      next_db = db_q;
      next_hold = hold_q;
      if (tick) begin
        if (btn_raw[g] == db_q) begin
          next_cnt = 3'h0;
        end else if (cnt == `SMC_DEB_TICKS - 3'h1) begin
          next_cnt = 3'h0;
          next_db = btn_raw[g];
        end else begin
          next_cnt = cnt + 3'h1;
        end
        if (db_q && hold_q != `SMC_HOLD_SAT) begin
          next_hold = hold_q + 13'h1;
        end
      end
      if (!next_db) begin
        next_hold = 13'h0;
      end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        cnt <= 3'h0;
        db_q <= 1'b0;
        press_q <= 1'b0;
        hold_q <= 13'h0;
      end else begin
        cnt <= next_cnt;
        db_q <= next_db;
        press_q <= next_db & ~db_q;
        hold_q <= next_hold;
      end
    end
    assign db[g] = db_q;
    assign press[g] = press_q;
    assign hold[g] = hold_q;
  end

  always_comb begin
    display_select_button_hit = tick && db[0] && hold[0] == `SMC_MENU_HOLD_MS - 13'h1;
    clr_hit = tick && db[1] && hold[1] == `SMC_CLR_HOLD_MS - 13'h1;
    next_state = state;
    next_item = item;
    next_edit = edit;
    next_tmr = (tick && tmr != `SMC_HOLD_SAT) ? tmr + 13'h1 : tmr;
    next_done_seen = done_seen | nv_write_done;
    next_station_addr = station_addr;
    next_baud_code = baud_code;
    next_fmt_code = fmt_code;
    ev = 3'h0;
    case (state)
      ST_IDLE: begin
        if (display_select_button_hit && seq_stopped && !start_in) begin
          next_state = ST_MENU;
          next_item = IT_PILOT;
          ev[`SMC_IRQ_MENU] = 1'b1;
        end
      end
      ST_MENU: begin
        if (display_select_button_hit) begin
          next_state = ST_IDLE;
        end else if (press[1]) begin
          case (item)
            IT_PILOT: next_state = ST_PILOT_ARM;
            IT_ADDR: next_edit = station_addr;
            IT_BAUD: next_edit = {4'h0, baud_code};
            IT_FMT: next_edit = {3'h0, fmt_code};
            default: next_edit = `SMC_CODE_MIN;
          endcase
          if (item == IT_INIT) begin
            next_state = ST_STORE;
            next_tmr = 13'h0;
            next_done_seen = 1'b0;
          end else if (item != IT_PILOT) begin
            next_state = ST_EDIT;
          end
        end else if (press[0]) begin
          next_item = (item == IT_INIT) ? IT_PILOT
            : smc_item_e'(item + 3'h1);
        end
      end
      ST_PILOT_ARM: begin
        if (start_in) begin
          next_state = ST_PILOT_RUN;
        end
      end
      ST_PILOT_RUN: begin
        if (!start_in) begin
          next_state = ST_PILOT_ARM;
        end
      end
      ST_EDIT: begin
        if (press[1]) begin
          // Commits ignore the supply level, so a 200 V unit on 100 V works.
          next_state = ST_STORE;
          next_tmr = 13'h0;
          next_done_seen = 1'b0;
        end else if (press[0]) begin
          case (item)
            IT_ADDR: next_edit = (edit == `SMC_ADDR_MAX) ? `SMC_CODE_MIN
              : edit + 6'h01;
            IT_BAUD: next_edit = (edit == `SMC_BAUD_MAX) ? `SMC_CODE_MIN
              : edit + 6'h01;
            default: next_edit = (edit == `SMC_FMT_MAX) ? `SMC_CODE_MIN
              : edit + 6'h01;
          endcase
        end
      end
      ST_STORE: begin
        // An abort mid-write leaves settings half written, so lock out.
        if (commit_abort) begin
          next_state = ST_LOCK;
          ev[`SMC_IRQ_LOCK] = 1'b1;
        end else if (done_seen && tmr >= `SMC_STORE_BLINK_MS) begin
          next_state = ST_MENU;
          ev[`SMC_IRQ_STORED] = 1'b1;
          case (item)
            IT_ADDR: next_station_addr = edit;
            IT_BAUD: next_baud_code = edit[1:0];
            IT_FMT: next_fmt_code = edit[2:0];
            default: begin
              next_station_addr = `SMC_ADDR_DEF;
              next_baud_code = 2'(`SMC_BAUD_DEF);
              next_fmt_code = 3'(`SMC_FMT_DEF);
            end
          endcase
        end
      end
      ST_LOCK: begin
        if (clr_hit) begin
          next_state = ST_IDLE;
          next_station_addr = `SMC_ADDR_DEF;
          next_baud_code = 2'(`SMC_BAUD_DEF);
          next_fmt_code = 3'(`SMC_FMT_DEF);
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_bcnt = (tick) ? bcnt + 13'h1 : bcnt;
    next_dot_on = dot_on;
    next_alt_sub = alt_sub;
    if (next_state == ST_LOCK) begin
      if (tick && bcnt == `SMC_ALT_MS - 13'h1) begin
        next_bcnt = 13'h0;
        next_alt_sub = ~alt_sub;
      end
    end else if (tick && bcnt == `SMC_DOT_HALF_MS - 13'h1) begin
      next_bcnt = 13'h0;
      next_dot_on = ~dot_on;
    end
    if (next_state == ST_IDLE || next_state == ST_LOCK) begin
      next_dot_on = 1'b0;
    end
    if (next_state != ST_LOCK) begin
      next_alt_sub = 1'b0;
    end
    next_display_select_button_value = next_edit;
    next_display_select_button_flash = 1'b0;
    case (next_state)
      ST_MENU: next_display_select_button_kind = DK_ITEM;
      ST_EDIT: next_display_select_button_kind = DK_VALUE;
      ST_PILOT_ARM: begin
        next_display_select_button_kind = DK_DASH;
        next_display_select_button_flash = 1'b1;
      end
      ST_PILOT_RUN: begin
        next_display_select_button_kind = DK_SEQ;
        next_display_select_button_flash = 1'b1;
      end
      ST_STORE: begin
        next_display_select_button_kind = DK_ITEM;
        next_display_select_button_flash = 1'b1;
      end
      ST_LOCK: next_display_select_button_kind = DK_ALARM;
      default: next_display_select_button_kind = DK_SEQ;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      item <= IT_PILOT;
      edit <= `SMC_CODE_MIN;
      tmr <= 13'h0;
      bcnt <= 13'h0;
      done_seen <= 1'b0;
      station_addr <= `SMC_ADDR_DEF;
      baud_code <= 2'(`SMC_BAUD_DEF);
      fmt_code <= 3'(`SMC_FMT_DEF);
      menu_active <= 1'b0;
      dot_on <= 1'b0;
      alt_sub <= 1'b0;
      display_select_button_kind <= DK_SEQ;
      display_select_button_item <= IT_PILOT;
      display_select_button_value <= `SMC_CODE_MIN;
      display_select_button_flash <= 1'b0;
      pilot_run <= 1'b0;
      main_valve1_only <= 1'b0;
      nv_write_req <= 1'b0;
      comm_lockout <= 1'b0;
    end else begin
      state <= next_state;
      item <= next_item;
      edit <= next_edit;
      tmr <= next_tmr;
      bcnt <= next_bcnt;
      done_seen <= next_done_seen;
      station_addr <= next_station_addr;
      baud_code <= next_baud_code;
      fmt_code <= next_fmt_code;
      menu_active <= next_state != ST_IDLE && next_state != ST_LOCK;
      dot_on <= next_dot_on;
      alt_sub <= next_alt_sub;
      display_select_button_kind <= next_display_select_button_kind;
      display_select_button_item <= next_item;
      display_select_button_value <= next_display_select_button_value;
      display_select_button_flash <= next_display_select_button_flash;
      pilot_run <= next_state == ST_PILOT_RUN;
      // The next mode bit keeps the valve flag in step with a mode write.
      main_valve1_only <= next_state == ST_PILOT_RUN &&
        next_direct_ign;
      nv_write_req <= next_state == ST_STORE && !next_done_seen;
      comm_lockout <= next_state == ST_LOCK;
    end
  end

  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [11:0] waddr, next_waddr;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane, next_irq;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr = waddr;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_direct_ign = direct_ign;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat | ev;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wbyte = s_axi_wdata[7:0];
      next_wlane = s_axi_wstrb[0];
    end
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `SMC_RESP_OKAY;
      case (waddr)
        `SMC_OFS_CTRL: if (wlane) next_direct_ign = wbyte[0];
        `SMC_OFS_IRQ_STAT: if (wlane) next_irq_stat =
          (irq_stat & ~wbyte[2:0]) | ev;
        `SMC_OFS_IRQ_MASK: if (wlane) next_irq_mask = wbyte[2:0];
        `SMC_OFS_STATUS, `SMC_OFS_SETTINGS: next_bresp = `SMC_RESP_OKAY;
        default: next_bresp = `SMC_RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `SMC_RESP_OKAY;
      case (s_axi_araddr)
        `SMC_OFS_CTRL: next_rdata = {31'h0, direct_ign};
        `SMC_OFS_STATUS: next_rdata = {24'h0, comm_lockout, item, 1'b0, state};
        `SMC_OFS_SETTINGS: next_rdata = {17'h0, fmt_code, 2'h0, baud_code,
          2'h0, station_addr};
        `SMC_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        `SMC_OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `SMC_RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
    next_irq = |(next_irq_stat & next_irq_mask);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 12'h0;
      wbyte <= 8'h0;
      wlane <= 1'b0;
      direct_ign <= 1'b0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      irq <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      direct_ign <= next_direct_ign;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  sequence s_commit_start;
    state == ST_EDIT && press[1];
  endsequence
  sequence s_commit_show;
    nv_write_req && display_select_button_flash && display_select_button_kind == DK_ITEM;
  endsequence
  a_menu_entry: assert property ($rose(menu_active) |->
    $past(display_select_button_hit && seq_stopped && !start_in && state == ST_IDLE))
    else $error("menu entered without a stopped 5 s hold");
  a_dot_period: assert property (menu_active && $past(menu_active) &&
    $changed(dot_on) |-> $past(tick && bcnt == `SMC_DOT_HALF_MS - 13'h1))
    else $error("centre dot toggled off its half period");
  a_item_cycle: assert property (state == ST_MENU && press[0] &&
    !press[1] && !display_select_button_hit |=> item == (($past(item) == IT_INIT) ?
    IT_PILOT : smc_item_e'($past(item) + 3'h1)))
    else $error("menu item did not advance cyclically");
  a_pilot_blink: assert property (pilot_run |->
    display_select_button_flash && display_select_button_kind == DK_SEQ)
    else $error("pilot test sequence code not blinking");
  a_valve_only: assert property (main_valve1_only |->
    pilot_run && direct_ign)
    else $error("main valve 1 driven outside direct pilot test");
  a_store_show: assert property (s_commit_start |=> s_commit_show)
    else $error("commit did not start with blinking item");
  a_addr_wrap: assert property (state == ST_EDIT && item == IT_ADDR &&
    press[0] && !press[1] && edit == `SMC_ADDR_MAX |=> edit == `SMC_CODE_MIN)
    else $error("address did not wrap to 1");
  a_baud_range: assert property (item == IT_BAUD &&
    state == ST_EDIT && press[0] && !press[1] && edit == 6'h03 |=>
    edit == 6'h01)
    else $error("baud code did not wrap from 3 to 1");
  a_abort_lock: assert property (state == ST_STORE && commit_abort |=>
    comm_lockout ##1 (comm_lockout && display_select_button_kind == DK_ALARM))
    else $error("aborted commit did not lock out");
  a_lock_clear: assert property ($fell(comm_lockout) |->
    station_addr == `SMC_ADDR_DEF && baud_code == 2'h3 && fmt_code == 3'h1)
    else $error("lockout clear did not restore defaults");
endmodule

/* File: smc_panel.sv */
`timescale 1ns/1ps
module smc_panel #(
  parameter int TK = 2
) (
  input wire logic sys_clk,
  output logic display_select_button,
  output logic reset_button
);
  logic [1:0] btn = 2'h0;
  assign display_select_button = btn[0];
  assign reset_button = btn[1];
  // Real contacts chatter at make and break, so every change bounces first.
  task automatic settle(input int b, input logic v, input int ms);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      btn[b] <= (i % 2 == 0) ? v : ~v;
    end
    @(posedge sys_clk);
    btn[b] <= v;
    repeat (ms * TK) @(posedge sys_clk);
  endtask
  task automatic press(input int b, input int ms);
    settle(b, 1'h1, ms);
    settle(b, 1'h0, 10);
  endtask
endmodule

/* File: smc_pkg.sv */
package smc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MENU = 3'b001,
    ST_PILOT_ARM = 3'b010,
    ST_PILOT_RUN = 3'b011,
    ST_EDIT = 3'b100,
    ST_STORE = 3'b101,
    ST_LOCK = 3'b110
  } smc_state_e;
  typedef enum logic [2:0] {
    IT_PILOT = 3'b000,
    IT_ADDR = 3'b001,
    IT_BAUD = 3'b010,
    IT_FMT = 3'b011,
    IT_INIT = 3'b100
  } smc_item_e;
  typedef enum logic [2:0] {
    DK_SEQ = 3'b000,
    DK_ITEM = 3'b001,
    DK_VALUE = 3'b010,
    DK_DASH = 3'b011,
    DK_ALARM = 3'b100
  } smc_display_select_button_e;
endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "smc_map.svh"
module tb_top import smc_pkg::*;;
  localparam int TK = 2;
  logic sys_clk = 1'h0, nrst = 1'h0, start_in = 1'h0, seq_stopped = 1'h1;
  // Start low: power and cable stay in place until the test pulses commit_abort once.
  logic nv_write_done = 1'h0, commit_abort = 1'h0;
  logic display_select_button, reset_button;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, baud_code;
  logic menu_active, dot_on, display_select_button_flash, alt_sub, pilot_run;
  logic main_valve1_only, nv_write_req, comm_lockout, irq;
  smc_display_select_button_e display_select_button_kind;
  smc_item_e display_select_button_item;
  logic [5:0] display_select_button_value, station_addr;
  logic [2:0] fmt_code;
  int miscompares = 0, tests_run = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n, k, np;
  int dflt[3] = '{1, 3, 1};
  int top[3] = '{32, 3, 4};
  logic [5:0] ev[3];

  always #5 sys_clk = ~sys_clk;

  smc_menu #(.TICK_CYCLES(TK)) uut (
    .sys_clk, .nrst, .display_select_button, .reset_button, .start_in,
    .seq_stopped, .nv_write_done, .commit_abort, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .menu_active, .dot_on, .display_select_button_kind, .display_select_button_item, .display_select_button_value,
    .display_select_button_flash, .alt_sub, .pilot_run, .main_valve1_only, .nv_write_req,
    .comm_lockout, .station_addr, .baud_code, .fmt_code, .irq
  );
  smc_panel #(.TK(TK)) u_panel (
    .sys_clk, .display_select_button, .reset_button
  );

  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int c, input int lim);
    @(posedge sys_clk);
    c++;
    if (c > lim) begin
      miscompares++;
      $display("FAIL %0t wait limit reached", $time);
      print_verdict();
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = display_select_button_flash;
      1: sig = nv_write_req;
      2: sig = comm_lockout;
      3: sig = dot_on;
      default: sig = alt_sub;
    endcase
  endfunction
  task automatic waitv(input int s, input logic v, input int lim,
                       output int c);
    c = 0;
    while (sig(s) !== v) tick(c, lim);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    int c;
    c = 0;
    @(posedge sys_clk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      tick(c, 100);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
    int c;
    c = 0;
    @(posedge sys_clk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      tick(c, 100);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
    end while (!s_axi_rvalid);
  endtask
  task automatic store(input int it);
    u_panel.press(1, 10);
    chk(display_select_button_flash, 1'h1);
    chk(nv_write_req, 1'h1);
    @(posedge sys_clk);
    nv_write_done <= 1'h1;
    @(posedge sys_clk);
    nv_write_done <= 1'h0;
    waitv(1, 1'h0, 20, n);
    waitv(0, 1'h0, 2100 * TK, n);
    chk({display_select_button_kind, display_select_button_item}, {DK_ITEM, 3'(it)});
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk(s_axi_bresp, bq.pop_front());
  end

  initial begin
    void'($urandom(38413));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk({station_addr, baud_code, fmt_code}, {6'h01, 2'h3, 3'h1});
    axi_rd(`SMC_OFS_SETTINGS, {`SMC_RESP_OKAY, 32'h00001301});
    axi_rd(12'h020, {`SMC_RESP_SLVERR, 32'h0});
    axi_wr(12'h020, 32'h1, 4'hF, `SMC_RESP_SLVERR);
    axi_wr(`SMC_OFS_CTRL, 32'h1, 4'h0, `SMC_RESP_OKAY);
    axi_rd(`SMC_OFS_CTRL, {`SMC_RESP_OKAY, 32'h0});
    axi_wr(`SMC_OFS_IRQ_MASK, 32'h7, 4'hF, `SMC_RESP_OKAY);
    start_in <= 1'h1;
    u_panel.press(0, 5100);
    chk(menu_active, 1'h0);
    start_in <= 1'h0;
    u_panel.press(0, 5100);
    chk({menu_active, irq}, 2'h3);
    chk({display_select_button_kind, display_select_button_item}, {DK_ITEM, IT_PILOT});
    axi_rd(`SMC_OFS_IRQ_STAT, {`SMC_RESP_OKAY, 32'h1});
    axi_wr(`SMC_OFS_IRQ_STAT, 32'h1, 4'hF, `SMC_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'h0);
    waitv(3, ~dot_on, 1100 * TK, n);
    waitv(3, ~dot_on, 1100 * TK, n);
    chk(n, 500 * TK);
    for (k = 1; k <= 5; k++) begin
      u_panel.press(0, 10);
      chk(display_select_button_item, k % 5);
    end
    // Address, baud and format in turn, each with a random step count.
    // The address always steps past 32 so that its wrap is exercised.
    for (k = 0; k < 3; k++) begin
      np = $urandom_range(40, 1) + ((k == 0) ? 31 : 0);
      ev[k] = 6'(((dflt[k] - 1 + np) % top[k]) + 1);
      u_panel.press(0, 10);
      chk(display_select_button_item, k + 1);
      u_panel.press(1, 10);
      chk({display_select_button_kind, display_select_button_value}, {DK_VALUE, 6'(dflt[k])});
      repeat (np) u_panel.press(0, 10);
      chk(display_select_button_value, ev[k]);
      store(k + 1);
    end
    chk({station_addr, baud_code, fmt_code},
        {ev[0], ev[1][1:0], ev[2][2:0]});
    axi_rd(`SMC_OFS_SETTINGS, {`SMC_RESP_OKAY, 32'(ev[0]) |
           (32'(ev[1]) << 8) | (32'(ev[2]) << 12)});
    // Initialise from the last item, then store address 2 by hand.
    u_panel.press(0, 10);
    store(4);
    chk({station_addr, baud_code, fmt_code}, {6'h01, 2'h3, 3'h1});
    repeat (2) u_panel.press(0, 10);
    u_panel.press(1, 10);
    u_panel.press(0, 10);
    store(1);
    chk(station_addr, 6'h02);
    axi_rd(`SMC_OFS_IRQ_STAT, {`SMC_RESP_OKAY, 32'h2});
    axi_wr(`SMC_OFS_IRQ_STAT, 32'h7, 4'hF, `SMC_RESP_OKAY);
    u_panel.press(1, 10);
    u_panel.press(0, 10);
    u_panel.press(1, 10);
    @(posedge sys_clk);
    commit_abort <= 1'h1;
    @(posedge sys_clk);
    commit_abort <= 1'h0;
    waitv(2, 1'h1, 20, n);
    @(posedge sys_clk);
    chk({display_select_button_kind, station_addr}, {DK_ALARM, 6'h02});
    waitv(4, ~alt_sub, 900 * TK, n);
    waitv(4, ~alt_sub, 900 * TK, n);
    chk(n, 800 * TK);
    axi_rd(`SMC_OFS_IRQ_STAT, {`SMC_RESP_OKAY, 32'h4});
    axi_rd(`SMC_OFS_STATUS, {`SMC_RESP_OKAY, 32'h96});
    u_panel.press(1, 1100);
    chk({comm_lockout, menu_active, dot_on}, 3'h0);
    chk({station_addr, baud_code, fmt_code}, {6'h01, 2'h3, 3'h1});
    u_panel.press(0, 5100);
    u_panel.press(1, 10);
    chk({display_select_button_kind, display_select_button_flash}, {DK_DASH, 1'h1});
    for (k = 1; k >= 0; k--) begin
      axi_wr(`SMC_OFS_CTRL, 32'(k), 4'hF, `SMC_RESP_OKAY);
      start_in <= 1'h1;
      repeat (10) @(posedge sys_clk);
      chk({pilot_run, display_select_button_kind, display_select_button_flash}, {1'h1, DK_SEQ, 1'h1});
      chk(main_valve1_only, k[0]);
      start_in <= 1'h0;
      repeat (10) @(posedge sys_clk);
      chk({pilot_run, display_select_button_kind}, {1'h0, DK_DASH});
    end
    print_verdict();
  end
endmodule
